// ===== kms_scanner.sv
// Key matrix scanner: scan sequencer, ghost check and key code buffer control
`default_nettype none

// Contract
// - Shared low-power clock runs while any peripheral requests it.
// - Disabled scanner never asserts its clock request.
// - Enabled scanner drops request with no keys, raises it on a press.
// - Columns programmable 1 to 20, rows 1 to 8, up to 160 keys.
// - Key codes held in a 16-byte buffer until read; on overflow new codes are dropped.
// - Full 160-key pass takes about 1.25 ms at 128 kHz.
// - Report any number of keys, lock out keys of a ghost pattern.
// - Debounce contacts and filter glitches before reporting a key.
// - Idle drives every column output high.
// - Idle row transition requests the clock and enters scan.
// - Idle clears row-hit register and key-index counter.
// - Row counter steps 0 to rows minus one, wraps, column advances.
// - Both counters at terminal count: leave scan for scan-end.
// - Key index advances on every scanned position.
// - Modifier keys matched against table; other indices go to buffer.
// - Columns with two or more hits OR row inputs into row-hit.
// - Hit in row already marked by earlier column sets ghost status.
// - Scan-end with keys seen returns to scan.
// - Scan-end with no keys returns to idle and drops request.
// - Key status readable at any time for polling.
module kms_scanner (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	// Configuration
	input  wire logic         enable_i,
	input  wire logic [3:0]   num_rows_i,
	input  wire logic [4:0]   num_cols_i,
	input  wire logic [63:0]  mod_codes_i,
	input  wire logic [7:0]   mod_valid_i,
	// Shared low-power clock
	input  wire logic         other_clk_req_i,
	output logic              clk_req_o,
	output logic              lp_clk_on_o,
	// Matrix pins
	input  wire logic [7:0]   row_i,
	output logic [19:0]       col_o,
	// Key code buffer read
	input  wire logic         kc_rd_i,
	output logic [7:0]        kc_data_o,
	output logic              kc_valid_o,
	// Status
	input  wire logic         ghost_clr_i,
	input  wire logic         ovf_clr_i,
	output logic              scanning_o,
	output logic              key_avail_o,
	output logic [4:0]        key_count_o,
	output logic              ghost_o,
	output logic              overflow_o,
	output logic [7:0]        mod_state_o
);

	// ************************************************************
	// State and buffer memory
	// ************************************************************
	kms_pkg::kms_state_t  cur;
	kms_pkg::kms_state_t  nxt;
	kms_buf_if            buf_if ();

	kms_key_mem kms_key_mem_i (
		.clock_i (clock_i),
		.bus     (buf_if.mem)
	);

	// ************************************************************
	// Scan helpers
	// ************************************************************
	logic        press_seen;
	logic        lp_on;
	logic        req;
	logic [2:0]  rows_m1;
	logic [4:0]  cols_m1;
	logic        row_now;
	logic        hit;
	logic        is_mod;
	logic [2:0]  mod_slot;
	logic [7:0]  col_hits_n;
	logic [3:0]  col_pop;
	logic        last_row;
	logic        last_col;
	logic        step;
	logic        push;
	logic        do_wr;
	logic        do_rd;

	// Rows pull down, a closed key lifts its row to a high column
	assign press_seen = (cur.row_sync != 8'h00);

	// Request the shared clock outside idle or on a sensed press
	assign req   = enable_i && ((cur.fsm != kms_pkg::KMS_IDLE) || press_seen);
	assign lp_on = req || other_clk_req_i;

	// Clamp programmed counts into the legal ranges
	always_comb begin
		if (num_rows_i == 4'h0) begin
			rows_m1 = 3'h0;
		end else if (num_rows_i > 4'h8) begin
			rows_m1 = kms_pkg::KMS_ROW_MAXM1;
		end else begin
			rows_m1 = 3'(num_rows_i - 4'h1);
		end
		if (num_cols_i == 5'h00) begin
			cols_m1 = 5'h00;
		end else if (num_cols_i > 5'h14) begin
			cols_m1 = kms_pkg::KMS_COL_MAXM1;
		end else begin
			cols_m1 = num_cols_i - 5'h01;
		end
	end

	// Key counts as hit only when pressed at mid-step and at end of step
	assign row_now  = cur.row_sync[cur.row_cnt];
	assign hit      = row_now && cur.mid_hit;
	assign step     = lp_on && (cur.tick == kms_pkg::KMS_TICK_LAST);
	assign last_row = (cur.row_cnt == rows_m1);
	assign last_col = (cur.col_cnt == cols_m1);

	// Compare the key index against the modifier table
	always_comb begin
		is_mod   = 1'b0;
		mod_slot = 3'h0;
		for (int i = 0; i < kms_pkg::KMS_MOD_SLOTS; i++) begin
			if (mod_valid_i[i] && (mod_codes_i[i*8 +: 8] == cur.key_idx)) begin
				is_mod   = 1'b1;
				mod_slot = 3'(i);
			end
		end
	end

	// Hits of the current column including the present row
	always_comb begin
		col_hits_n = cur.col_hits;
		if (hit) begin
			col_hits_n[cur.row_cnt] = 1'b1;
		end
		col_pop = 4'h0;
		for (int i = 0; i < kms_pkg::KMS_ROWS; i++) begin
			col_pop = col_pop + {3'h0, col_hits_n[i]};
		end
	end

	// Non-modifier, non-ghost key codes are pushed into the buffer
	assign push  = (cur.fsm == kms_pkg::KMS_SCAN) && step && hit && !is_mod
		&& !cur.row_hit[cur.row_cnt];
	assign do_wr = push && (cur.count != kms_pkg::KMS_BUF_FULL);
	assign do_rd = kc_rd_i && (cur.count != 5'h00);

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		nxt          = cur;
		nxt.row_meta = row_i;
		nxt.row_sync = cur.row_meta;
		nxt.rd_pend  = do_rd;

		// Step timer runs only while the low-power clock is on
		if (!lp_on || step) begin
			nxt.tick = 10'h000;
		end else begin
			nxt.tick = cur.tick + 10'h001;
		end
		if (lp_on && (cur.tick == kms_pkg::KMS_TICK_MID)) begin
			nxt.mid_hit = row_now;
		end

		case (cur.fsm)
			kms_pkg::KMS_IDLE: begin
				nxt.col_sel  = 20'h00000;
				nxt.row_hit  = 8'h00;
				nxt.key_idx  = 8'h00;
				nxt.row_cnt  = 3'h0;
				nxt.col_cnt  = 5'h00;
				nxt.col_hits = 8'h00;
				nxt.any_key  = 1'b0;
				nxt.mod_acc  = 8'h00;
				if (enable_i && press_seen) begin
					nxt.fsm     = kms_pkg::KMS_SCAN;
					nxt.col_sel = 20'h00001;
					nxt.tick    = 10'h000;
				end
			end
			kms_pkg::KMS_SCAN: begin
				if (step) begin
					nxt.key_idx = cur.key_idx + 8'h01;
					if (hit) begin
						nxt.any_key = 1'b1;
						if (is_mod) begin
							nxt.mod_acc[mod_slot] = 1'b1;
						end
						if (cur.row_hit[cur.row_cnt]) begin
							nxt.ghost = 1'b1;
						end
					end
					nxt.col_hits = col_hits_n;
					if (last_row) begin
						nxt.row_cnt  = 3'h0;
						nxt.col_hits = 8'h00;
						if (col_pop >= 4'h2) begin
							nxt.row_hit = cur.row_hit | cur.row_sync;
						end
						if (last_col) begin
							nxt.fsm     = kms_pkg::KMS_SCAN_END;
							nxt.col_sel = 20'h00000;
						end else begin
							nxt.col_cnt = cur.col_cnt + 5'h01;
							nxt.col_sel = cur.col_sel << 1;
						end
					end else begin
						nxt.row_cnt = cur.row_cnt + 3'h1;
					end
				end
			end
			kms_pkg::KMS_SCAN_END: begin
				nxt.mod_state = cur.mod_acc;
				nxt.row_cnt   = 3'h0;
				nxt.col_cnt   = 5'h00;
				nxt.key_idx   = 8'h00;
				nxt.row_hit   = 8'h00;
				nxt.col_hits  = 8'h00;
				nxt.mod_acc   = 8'h00;
				nxt.any_key   = 1'b0;
				nxt.tick      = 10'h000;
				if (cur.any_key) begin
					nxt.fsm     = kms_pkg::KMS_SCAN;
					nxt.col_sel = 20'h00001;
				end else begin
					nxt.fsm     = kms_pkg::KMS_IDLE;
					nxt.col_sel = 20'h00000;
				end
			end
			default: begin
				nxt.fsm     = kms_pkg::KMS_IDLE;
				nxt.col_sel = 20'h00000;
			end
		endcase

		// Disabling forces idle with columns high
		if (!enable_i) begin
			nxt.fsm      = kms_pkg::KMS_IDLE;
			nxt.col_sel  = 20'h00000;
			nxt.row_hit  = 8'h00;
			nxt.key_idx  = 8'h00;
			nxt.row_cnt  = 3'h0;
			nxt.col_cnt  = 5'h00;
			nxt.col_hits = 8'h00;
			nxt.any_key  = 1'b0;
			nxt.mod_acc  = 8'h00;
		end

		// Sticky flags: a set in the clearing cycle wins
		if (ghost_clr_i && !(cur.fsm == kms_pkg::KMS_SCAN && step && hit
			&& cur.row_hit[cur.row_cnt])) begin
			nxt.ghost = 1'b0;
		end
		if (push && !do_wr) begin
			nxt.ovf = 1'b1;
		end else if (ovf_clr_i) begin
			nxt.ovf = 1'b0;
		end

		// Buffer pointers and fill count
		if (do_wr) begin
			nxt.wr_ptr = cur.wr_ptr + 4'h1;
		end
		if (do_rd) begin
			nxt.rd_ptr = cur.rd_ptr + 4'h1;
		end
		case ({do_wr, do_rd})
			2'b10:   nxt.count = cur.count + 5'h01;
			2'b01:   nxt.count = cur.count - 5'h01;
			default: nxt.count = cur.count;
		endcase
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			cur <= kms_pkg::KMS_STATE_RST;
		end else begin
			cur <= nxt;
		end
	end

	// ************************************************************
	// Buffer memory connections
	// ************************************************************
	assign buf_if.wr_en   = do_wr;
	assign buf_if.wr_addr = cur.wr_ptr;
	assign buf_if.wr_data = cur.key_idx;
	assign buf_if.rd_en   = do_rd;
	assign buf_if.rd_addr = cur.rd_ptr;

	// ************************************************************
	// Outputs
	// ************************************************************
	assign clk_req_o   = req;
	assign lp_clk_on_o = lp_on;
	// Only the scanned column is high in scan, all columns high otherwise
	assign col_o       = (cur.fsm == kms_pkg::KMS_SCAN) ? cur.col_sel : 20'hFFFFF;
	assign kc_data_o   = buf_if.rd_data;
	assign kc_valid_o  = cur.rd_pend;
	assign scanning_o  = (cur.fsm != kms_pkg::KMS_IDLE);
	assign key_avail_o = (cur.count != 5'h00);
	assign key_count_o = cur.count;
	assign ghost_o     = cur.ghost;
	assign overflow_o  = cur.ovf;
	assign mod_state_o = cur.mod_state;

endmodule // kms_scanner

`default_nettype wire

// ===== kms_pkg.sv
// Package: constants and state types of the key matrix scanner
`default_nettype none

package kms_pkg;

	// ************************************************************
	// Clocking and scan timing
	// ************************************************************
	localparam int          KMS_CLK_HZ     = 100_000_000;       // System clock rate
	localparam int          KMS_LP_CLK_HZ  = 128_000;           // Low-power scan clock rate
	localparam int          KMS_TICK_CYC   = KMS_CLK_HZ / KMS_LP_CLK_HZ; // Cycles per key step
	localparam logic [9:0]  KMS_TICK_LAST  = 10'(KMS_TICK_CYC - 1);
	localparam logic [9:0]  KMS_TICK_MID   = 10'(KMS_TICK_CYC / 2);

	// ************************************************************
	// Matrix geometry
	// ************************************************************
	localparam int          KMS_ROWS       = 8;
	localparam int          KMS_COLS       = 20;
	localparam logic [2:0]  KMS_ROW_MAXM1  = 3'h7;              // Highest row counter value
	localparam logic [4:0]  KMS_COL_MAXM1  = 5'h13;             // Highest column counter value
	localparam int          KMS_MOD_SLOTS  = 8;                 // Modifier key code entries

	// ************************************************************
	// Key code buffer
	// ************************************************************
	localparam int          KMS_BUF_DEPTH  = 16;
	localparam int          KMS_BUF_AW     = 4;
	localparam logic [4:0]  KMS_BUF_FULL   = 5'h10;

	// ************************************************************
	// Controller state
	// ************************************************************
	typedef enum logic [1:0] {
		KMS_IDLE,
		KMS_SCAN,
		KMS_SCAN_END
	} kms_fsm_t;

	typedef struct packed {
		kms_fsm_t                fsm;
		logic [7:0]              row_meta;   // Synchroniser first stage
		logic [7:0]              row_sync;   // Synchroniser second stage
		logic [9:0]              tick;
		logic                    mid_hit;
		logic [2:0]              row_cnt;
		logic [4:0]              col_cnt;
		logic [7:0]              key_idx;
		logic [7:0]              row_hit;
		logic [7:0]              col_hits;
		logic [19:0]             col_sel;    // Set bit drives that column high in scan
		logic                    any_key;
		logic                    ghost;
		logic                    ovf;
		logic [7:0]              mod_acc;
		logic [7:0]              mod_state;
		logic [KMS_BUF_AW-1:0]   wr_ptr;
		logic [KMS_BUF_AW-1:0]   rd_ptr;
		logic [4:0]              count;
		logic                    rd_pend;
	} kms_state_t;

	localparam kms_state_t  KMS_STATE_RST  = '0;

endpackage : kms_pkg

`default_nettype wire

// ===== kms_buf_if.sv
// Interface: write and read ports of the key code buffer memory
`default_nettype none

interface kms_buf_if;
	logic        wr_en;
	logic [3:0]  wr_addr;
	logic [7:0]  wr_data;
	logic        rd_en;
	logic [3:0]  rd_addr;
	logic [7:0]  rd_data;

	modport ctrl (
		output wr_en, wr_addr, wr_data, rd_en, rd_addr,
		input  rd_data
	);

	modport mem (
		input  wr_en, wr_addr, wr_data, rd_en, rd_addr,
		output rd_data
	);
endinterface : kms_buf_if

`default_nettype wire

// ===== kms_key_mem.sv
// Key code buffer storage: 16 bytes with registered read data
`default_nettype none

module kms_key_mem (
	// Clock
	input  wire logic  clock_i,
	// Buffer access
	kms_buf_if.mem     bus
);

	logic [7:0] mem [kms_pkg::KMS_BUF_DEPTH];
	logic [7:0] rd_q;

	// Write port and registered read port
	always_ff @(posedge clock_i) begin
		if (bus.wr_en) begin
			mem[bus.wr_addr] <= bus.wr_data;
		end
		if (bus.rd_en) begin
			rd_q <= mem[bus.rd_addr];
		end
	end

	assign bus.rd_data = rd_q;

endmodule // kms_key_mem

`default_nettype wire

// ===== kms_scanner_properties.sv
// Checker: port-level properties of the key matrix scanner
`default_nettype none

module kms_scanner_properties (
	// Clock and reset
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	// Watched ports
	input wire logic        enable_i,
	input wire logic        other_clk_req_i,
	input wire logic        clk_req_o,
	input wire logic        lp_clk_on_o,
	input wire logic [19:0] col_o,
	input wire logic        kc_rd_i,
	input wire logic        kc_valid_o,
	input wire logic        ghost_clr_i,
	input wire logic        ovf_clr_i,
	input wire logic        scanning_o,
	input wire logic        key_avail_o,
	input wire logic [4:0]  key_count_o,
	input wire logic        ghost_o,
	input wire logic        overflow_o
);
	// One clock domain, checks held off in reset
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	// ************************************************************
	// Clock request and column drive
	// ************************************************************
	a_off_no_req: assert property (!enable_i |-> !clk_req_o)
		else $error("clock requested while disabled");
	a_shared_clock: assert property (lp_clk_on_o == (clk_req_o | other_clk_req_i))
		else $error("shared clock enable wrong");
	a_idle_cols_high: assert property (!scanning_o |-> col_o == 20'hFFFFF)
		else $error("column low while idle");
	a_scan_holds_req: assert property (scanning_o && enable_i |-> clk_req_o)
		else $error("request dropped during scan");
	a_idle_wakes: assert property (enable_i && !scanning_o && clk_req_o |=> scanning_o)
		else $error("press in idle did not start scan");
	a_one_col_high: assert property (scanning_o && col_o != 20'hFFFFF |-> $onehot(col_o))
		else $error("more than one column driven");

	// ************************************************************
	// Buffer and status flags
	// ************************************************************
	a_pop_answer: assert property (kc_rd_i && key_count_o != 5'h00 |=> kc_valid_o)
		else $error("pop not answered");
	a_avail_count: assert property (key_avail_o == (key_count_o != 5'h00))
		else $error("available flag disagrees with count");
	a_ovf_sticky: assert property (overflow_o && !ovf_clr_i |=> overflow_o)
		else $error("overflow flag lost");
	a_ghost_sticky: assert property (ghost_o && !ghost_clr_i |=> ghost_o)
		else $error("ghost flag lost");
	a_ovf_when_full: assert property ($rose(overflow_o) |-> $past(key_count_o) == 5'h10)
		else $error("overflow without full buffer");

	// Main scenarios reached
	c_scan: cover property ($rose(scanning_o));
	c_pop: cover property (kc_valid_o);
	c_ghost: cover property ($rose(ghost_o));
	c_ovf: cover property ($rose(overflow_o));
endmodule // kms_scanner_properties

bind kms_scanner kms_scanner_properties kms_scanner_properties_i (
	.clock_i, .rst_n_i, .enable_i, .other_clk_req_i, .clk_req_o, .lp_clk_on_o,
	.col_o, .kc_rd_i, .kc_valid_o, .ghost_clr_i, .ovf_clr_i, .scanning_o,
	.key_avail_o, .key_count_o, .ghost_o, .overflow_o
);

`default_nettype wire

// ===== kms_matrix_model.sv
// Switch matrix model: pulled-down rows closed onto columns by held keys
`default_nettype none

module kms_matrix_model (
	// Column drive from the scanner
	input  wire logic [19:0]  col_i,
	// Held keys, bit c*8+r joins row r to column c
	input  wire logic [159:0] keys_i,
	// Row lines back to the scanner
	output logic [7:0]        row_o
);
	// Passive switches: a row only rises through a key on a high column
	always_comb begin
		row_o = 8'h00;
		for (int c = 0; c < 20; c++) begin
			for (int r = 0; r < 8; r++) begin
				if (keys_i[c*8+r] && col_i[c]) begin
					row_o[r] = 1'b1;
				end
			end
		end
	end
endmodule // kms_matrix_model

`default_nettype wire

// ===== kms_scanner_test.sv
// Testbench: directed scans, buffer reads and flag checks of the key matrix scanner
`default_nettype none

module kms_scanner_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Signals and instances
	// ************************************************************
	localparam int WSCAN = 0, WAVAIL = 1, WGHOST = 2, WOVF = 3, WMOD = 4;
	logic         clock_i = 1'b0;
	logic         rst_n_i = 1'b0;
	logic         enable_i = 1'b0;
	logic [3:0]   num_rows_i = 4'h2;
	logic [4:0]   num_cols_i = 5'h02;
	logic [63:0]  mod_codes_i = 64'h0000000000000002;
	logic [7:0]   mod_valid_i = 8'h00;
	logic         other_clk_req_i = 1'b0;
	logic         kc_rd_i = 1'b0;
	logic         ghost_clr_i = 1'b0;
	logic         ovf_clr_i = 1'b0;
	logic [159:0] keys = '0;
	logic [7:0]   row_i, kc_data_o, mod_state_o;
	logic [19:0]  col_o;
	logic [4:0]   key_count_o;
	logic         clk_req_o, lp_clk_on_o, kc_valid_o, scanning_o;
	logic         key_avail_o, ghost_o, overflow_o;
	int           fail_count = 0;
	int           n_tests = 0;

	// 100 MHz clock
	always #5 clock_i = ~clock_i;

	kms_scanner kms_scanner_i (.clock_i, .rst_n_i, .enable_i, .num_rows_i, .num_cols_i,
		.mod_codes_i, .mod_valid_i, .other_clk_req_i, .clk_req_o, .lp_clk_on_o, .row_i,
		.col_o, .kc_rd_i, .kc_data_o, .kc_valid_o, .ghost_clr_i, .ovf_clr_i, .scanning_o,
		.key_avail_o, .key_count_o, .ghost_o, .overflow_o, .mod_state_o);
	kms_matrix_model kms_matrix_model_i (.col_i(col_o), .keys_i(keys), .row_o(row_i));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic give_verdict();
		$display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Four-state compare of any result
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Settled sampling just after an edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// Bounded wait for one status output to reach a level
	task automatic wait_until(input int sel, input logic lvl);
		logic v;
		for (int i = 0; i < 30000; i++) begin
			cyc(1);
			case (sel)
				WSCAN: v = scanning_o;
				WAVAIL: v = key_avail_o;
				WGHOST: v = ghost_o;
				WOVF: v = overflow_o;
				default: v = mod_state_o[0];
			endcase
			if (v === lvl) return;
		end
		fail_count++;
		$display("CHECK FAILED at %0t: got %h expected %h", $time, ~lvl, lvl);
		give_verdict();
	endtask

	// One pop pulse, answer looked at one cycle later
	task automatic pop(input logic exp_v, input logic [7:0] exp_d);
		@(posedge clock_i);
		kc_rd_i <= 1'b1;
		@(posedge clock_i);
		kc_rd_i <= 1'b0;
		#1;
		chk(kc_valid_o, exp_v);
		if (exp_v) chk(kc_data_o, exp_d);
	endtask

	// Empty the buffer, codes alternate between a and b
	task automatic drain(input logic [7:0] a, input logic [7:0] b);
		for (int i = 0; i < 20 && key_avail_o === 1'b1; i++) begin
			pop(1'b1, i[0] ? b : a);
		end
		chk(key_count_o, 0);
	endtask

	// ************************************************************
	// Test sequence
	// ************************************************************
	initial begin
		repeat (4) @(posedge clock_i);
		rst_n_i <= 1'b1;
		cyc(3);
		chk({clk_req_o, scanning_o, key_count_o, col_o}, {7'h00, 20'hFFFFF});
		// Key at row 1, column 1 held while disabled, other unit owns the clock
		@(posedge clock_i);
		other_clk_req_i <= 1'b1;
		keys[9] <= 1'b1;
		cyc(50);
		chk({clk_req_o, lp_clk_on_o, scanning_o}, 3'h2);
		@(posedge clock_i);
		enable_i <= 1'b1;
		other_clk_req_i <= 1'b0;
		wait_until(WSCAN, 1'b1);
		chk(col_o, 20'h00001);
		cyc(kms_pkg::KMS_TICK_CYC * 5 / 2);
		chk({clk_req_o, col_o}, {1'b1, 20'h00002});
		wait_until(WAVAIL, 1'b1);
		@(posedge clock_i);
		keys <= '0;
		wait_until(WSCAN, 1'b0);
		chk({clk_req_o, key_count_o}, {1'b0, 5'h01});
		drain(8'h03, 8'h03);
		$display("Test single key done");
		// Modifier at index 2 goes to modifier state, not the buffer
		@(posedge clock_i);
		mod_valid_i <= 8'h01;
		keys[8] <= 1'b1;
		wait_until(WMOD, 1'b1);
		@(posedge clock_i);
		keys <= '0;
		wait_until(WSCAN, 1'b0);
		chk(key_count_o, 0);
		$display("Test modifier done");
		// Three corners of a square: third key is a ghost
		@(posedge clock_i);
		mod_valid_i <= 8'h00;
		keys <= 160'h103;
		wait_until(WGHOST, 1'b1);
		@(posedge clock_i);
		keys <= '0;
		wait_until(WSCAN, 1'b0);
		chk({ghost_o, key_count_o}, {1'b1, 5'h02});
		drain(8'h00, 8'h01);
		@(posedge clock_i);
		ghost_clr_i <= 1'b1;
		@(posedge clock_i);
		ghost_clr_i <= 1'b0;
		cyc(1);
		chk(ghost_o, 0);
		$display("Test ghost done");
		// Smallest matrix, key held until the buffer overflows
		@(posedge clock_i);
		num_rows_i <= 4'h1;
		num_cols_i <= 5'h01;
		keys <= 160'h1;
		wait_until(WOVF, 1'b1);
		chk(key_count_o, 16);
		@(posedge clock_i);
		keys <= '0;
		wait_until(WSCAN, 1'b0);
		chk({overflow_o, key_count_o}, {1'b1, 5'h10});
		@(posedge clock_i);
		ovf_clr_i <= 1'b1;
		@(posedge clock_i);
		ovf_clr_i <= 1'b0;
		cyc(1);
		chk(overflow_o, 0);
		drain(8'h00, 8'h00);
		pop(1'b0, 8'h00);
		$display("Test overflow done");
		give_verdict();
	end
endmodule // kms_scanner_test

`default_nettype wire
